// ===== verilog/ext_mem_record_address_gen.sv
// record address generator for the external memory tables
`default_nettype none
module ext_mem_record_address_gen (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // access request and registered answer
   input  wire logic                      req_valid,
   input  wire rec_addr_pkg::access_req_t req,
   input  wire logic                      cell_tick,
   output rec_addr_pkg::access_rsp_t      rsp
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0] regs_q [rec_addr_pkg::NUM_REGS];
   logic [23:0] last_addr_q;
   logic [15:0] cell_time_count_q;
   logic        apb_access;
   logic [4:0]  reg_idx;
   logic        reg_hit;

   assign apb_access = psel & penable;
   assign reg_idx    = paddr[6:2];
   assign reg_hit    = (paddr[1:0] == 2'b00) && (paddr[7] == 1'b0) && (reg_idx < 5'(rec_addr_pkg::NUM_REGS));

   function automatic logic [23:0] base_of(input logic [31:0] r);
      base_of = {r[rec_addr_pkg::BASE_HI:rec_addr_pkg::BASE_LO], 8'h00};
   endfunction : base_of

   function automatic logic [23:0] scaled(input logic [15:0] id, input logic [3:0] words);
      logic [19:0] prod;
      prod   = 20'(id) * 20'(words);
      scaled = {2'b00, prod, 2'b00};
   endfunction : scaled

   // ---------------------------------------------------------------
   // apb slave, writes to read-only words are refused
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < rec_addr_pkg::NUM_REGS; i++) begin
            regs_q[i] <= rec_addr_pkg::RESET_VALUE;
         end
      end else if (apb_access && pwrite && reg_hit && paddr < rec_addr_pkg::OFS_LAST_ADDR) begin
         regs_q[reg_idx] <= pwdata;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable) begin
            pslverr <= ~reg_hit | (pwrite & (paddr >= rec_addr_pkg::OFS_LAST_ADDR));
            if (!reg_hit) begin
               prdata <= 32'h0000_0000;
            end else if (paddr == rec_addr_pkg::OFS_LAST_ADDR) begin
               prdata <= {8'h00, last_addr_q};
            end else if (paddr == rec_addr_pkg::OFS_CELL_TIME) begin
               prdata <= {16'h0000, cell_time_count_q};
            end else begin
               prdata <= regs_q[reg_idx];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // free-running cell time counter
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cell_time_count_q <= 16'h0000;
      end else if (cell_tick) begin
         cell_time_count_q <= cell_time_count_q + 16'h0001;
      end
   end

   // ---------------------------------------------------------------
   // address arithmetic
   // ---------------------------------------------------------------
   logic [31:0] gcfg;
   logic [31:0] lcw;
   logic [3:0]  cnt_words;
   logic [3:0]  ctx_words;
   logic [2:0]  dump_ctl;
   logic [11:0] path_index;
   logic [15:0] conn_id;
   logic [21:0] bucket_ptr;
   logic [15:0] monitor_ptr;
   logic [1:0]  bucket_count;
   logic [19:0] mcast_term;
   logic [15:0] dump_bits;
   logic [23:0] addr_d;

   assign gcfg      = regs_q[rec_addr_pkg::OFS_GLOBAL_CFG[6:2]];
   assign lcw       = regs_q[rec_addr_pkg::OFS_LINK_CFG[6:2]];
   assign cnt_words = {2'b00, gcfg[rec_addr_pkg::GCFG_NWORDS_LO +: 2]} + 4'h1;
   // absent long words only shorten the record, the rest keep their order
   assign ctx_words = {1'b0, gcfg[rec_addr_pkg::GCFG_CTXW_LO +: 3]} + 4'h1;
   assign dump_ctl  = gcfg[rec_addr_pkg::GCFG_DUMP_LO +: 3];
   // path_index_mask sits in the top byte and bits 7:4 of link_config_word
   assign path_index = req.path_id & {lcw[31:24], lcw[7:4]};
   assign conn_id    = req.use_egress ? req.egr_conn_id : req.ing_conn_id;

   // common word decode per monitor-all-connections setting
   always_comb begin
      if (gcfg[rec_addr_pkg::GCFG_MONALL]) begin
         bucket_count = req.common_word[29:28];
         bucket_ptr   = {10'h000, req.common_word[27:16]};
         monitor_ptr  = req.common_word[15:0];
      end else begin
         bucket_count = 2'b00;
         bucket_ptr   = {6'h00, req.common_word[15:0]};
         monitor_ptr  = {4'h0, req.common_word[29:18]};
      end
   end

   // multicast identifier width is nine plus the control field
   always_comb begin
      logic [15:0] ident_mask;
      ident_mask = 16'hFFFF >> (4'h7 - 4'(regs_q[rec_addr_pkg::OFS_MCAST_CFG[6:2]][2:0]));
      mcast_term = {req.mcast_section, 16'h0000} | {4'h0, req.mcast_ident & ident_mask};
      if (regs_q[rec_addr_pkg::OFS_MCAST_CFG[6:2]][2:0] < 3'h7) begin
         mcast_term = {4'h0, req.mcast_ident & ident_mask}
                    | (20'(req.mcast_section) << (5'd9 + 5'(regs_q[rec_addr_pkg::OFS_MCAST_CFG[6:2]][2:0])));
      end
   end

   // counter bits used: 2*(ctl+2)+1, at most 16
   always_comb begin
      logic [4:0] nbits;
      nbits     = 5'(2 * (32'(dump_ctl) + 2) + 1);
      dump_bits = (nbits >= 5'd16) ? cell_time_count_q
                : (cell_time_count_q & 16'((32'h1 << nbits) - 1));
   end

   always_comb begin
      case (req.table_sel)
         rec_addr_pkg::TBL_ING_BILL:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_ING_BILL[6:2]]) + scaled(req.ing_conn_id, cnt_words);
         rec_addr_pkg::TBL_POLICE:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_POLICE[6:2]]) + scaled(req.ing_conn_id, cnt_words);
         rec_addr_pkg::TBL_EGR_BILL:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_EGR_BILL[6:2]]) + scaled(req.egr_conn_id, cnt_words);
         rec_addr_pkg::TBL_FLAG:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_FLAG[6:2]]) + scaled(req.ing_conn_id, 4'h1);
         rec_addr_pkg::TBL_CTX:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_CTX[6:2]]) + scaled(conn_id, ctx_words);
         rec_addr_pkg::TBL_CTX_EXT:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_CTX_EXT[6:2]]) + scaled(conn_id, 4'h1);
         rec_addr_pkg::TBL_PATH:
            if (gcfg[rec_addr_pkg::GCFG_CHAN_EN]) begin
               addr_d = {lcw[23:8], 8'h00} + {10'h000, path_index, 2'b00};
            end else begin
               addr_d = {lcw[15:0], 8'h00} + {11'h000, path_index, 1'b0};
            end
         rec_addr_pkg::TBL_CHAN:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_CHAN[6:2]]) + {6'h00, req.chan_offset, 2'b00}
                   + {7'h00, req.chan_id & req.chan_index_mask, 1'b0};
         rec_addr_pkg::TBL_MCAST:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_MCAST[6:2]]) + {3'h0, mcast_term, 1'b0};
         rec_addr_pkg::TBL_BUCKET:
            addr_d = {bucket_ptr, 2'b00};
         rec_addr_pkg::TBL_MONITOR:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_MONITOR[6:2]]) + 24'({monitor_ptr, 5'h00});
         rec_addr_pkg::TBL_DUMP:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_DUMP[6:2]]) + {5'h00, dump_bits, 3'h0};
         rec_addr_pkg::TBL_ING_LINK:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_ING_LINK[6:2]])
                   + scaled({11'h000, req.link_num}, rec_addr_pkg::ING_LINK_WORDS);
         rec_addr_pkg::TBL_EGR_LINK:
            addr_d = base_of(regs_q[rec_addr_pkg::OFS_EGR_LINK[6:2]])
                   + scaled({11'h000, req.link_num}, rec_addr_pkg::EGR_LINK_WORDS);
         default:
            addr_d = 24'h00_0000;
      endcase
   end

   // ---------------------------------------------------------------
   // answer register, one cycle after the request
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rsp         <= '0;
         last_addr_q <= 24'h00_0000;
      end else begin
         rsp.valid      <= req_valid;
         rsp.addr       <= addr_d;
         rsp.word_wide  <= (req.table_sel == rec_addr_pkg::TBL_FLAG) || (req.table_sel == rec_addr_pkg::TBL_CHAN)
                         || (req.table_sel == rec_addr_pkg::TBL_MCAST)
                         || (req.table_sel == rec_addr_pkg::TBL_PATH && !gcfg[rec_addr_pkg::GCFG_CHAN_EN]);
         rsp.no_bucket  <= (bucket_ptr == (gcfg[rec_addr_pkg::GCFG_MONALL] ? 22'h00_0FFF : 22'h00_FFFF));
         rsp.bucket_num <= (bucket_count == 2'b00) ? 3'h4 : {1'b0, bucket_count};
         // both valid flags sit in the top bits in either common word layout
         rsp.mon_valid  <= req.common_word[rec_addr_pkg::COMMON_ING_MON_PTR_VALID]
                         | req.common_word[rec_addr_pkg::COMMON_EGR_MON_PTR_VALID];
         if (req_valid) begin
            last_addr_q <= addr_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_valid_follows;
      @(posedge clk_sys) disable iff (!arst_n) req_valid |=> rsp.valid;
   endproperty
   a_valid_follows: assert property (p_valid_follows) else $error("answer missing");

   property p_bucket_nobase;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_BUCKET |=> rsp.addr[1:0] == 2'b00;
   endproperty
   a_bucket_nobase: assert property (p_bucket_nobase) else $error("bucket address misaligned");

   property p_flag_word;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_FLAG |=> rsp.word_wide;
   endproperty
   a_flag_word: assert property (p_flag_word) else $error("flags access not word wide");

   property p_bucket_four;
      @(posedge clk_sys) disable iff (!arst_n)
         gcfg[rec_addr_pkg::GCFG_MONALL] && req.common_word[29:28] == 2'b00 |=> rsp.bucket_num == 3'h4;
   endproperty
   a_bucket_four: assert property (p_bucket_four) else $error("bucket count decode wrong");

   property p_ctx_ext_step;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_CTX_EXT && conn_id == 16'h0000
         |=> rsp.addr == $past(base_of(regs_q[rec_addr_pkg::OFS_CTX_EXT[6:2]]));
   endproperty
   a_ctx_ext_step: assert property (p_ctx_ext_step) else $error("extension base wrong");

   property p_monitor_align;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_MONITOR |=> rsp.addr[4:0] == 5'h00;
   endproperty
   a_monitor_align: assert property (p_monitor_align) else $error("monitor record misaligned");

   property p_dump_align;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_DUMP |=> rsp.addr[2:0] == 3'h0;
   endproperty
   a_dump_align: assert property (p_dump_align) else $error("dump vector misaligned");

   property p_last_addr;
      @(posedge clk_sys) disable iff (!arst_n)
         req_valid |=> last_addr_q == rsp.addr;
   endproperty
   a_last_addr: assert property (p_last_addr) else $error("last address not captured");

   property p_path_word;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_PATH && !gcfg[rec_addr_pkg::GCFG_CHAN_EN] |=> rsp.word_wide;
   endproperty
   a_path_word: assert property (p_path_word) else $error("path entry not word wide");

   property p_no_bucket;
      @(posedge clk_sys) disable iff (!arst_n)
         !gcfg[rec_addr_pkg::GCFG_MONALL] && req.common_word[15:0] == 16'hFFFF |=> rsp.no_bucket;
   endproperty
   a_no_bucket: assert property (p_no_bucket) else $error("missing bucket not flagged");

   property p_mon_valid;
      @(posedge clk_sys) disable iff (!arst_n)
         req.common_word[rec_addr_pkg::COMMON_ING_MON_PTR_VALID] || req.common_word[rec_addr_pkg::COMMON_EGR_MON_PTR_VALID]
         |=> rsp.mon_valid;
   endproperty
   a_mon_valid: assert property (p_mon_valid) else $error("monitor pointer valid lost");

   property p_bucket_addr;
      @(posedge clk_sys) disable iff (!arst_n)
         req.table_sel == rec_addr_pkg::TBL_BUCKET && !gcfg[rec_addr_pkg::GCFG_MONALL]
         |=> rsp.addr == {6'h00, $past(req.common_word[15:0]), 2'b00};
   endproperty
   a_bucket_addr: assert property (p_bucket_addr) else $error("bucket address wrong");

endmodule : ext_mem_record_address_gen
`default_nettype wire

// ===== verilog/rec_addr_pkg.sv
// package for the external memory record address generator
`default_nettype none
package rec_addr_pkg;
   // ---------------------------------------------------------------
   // apb register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_ING_BILL     = 8'h00;
   localparam logic [7:0] OFS_POLICE       = 8'h04;
   localparam logic [7:0] OFS_EGR_BILL     = 8'h08;
   localparam logic [7:0] OFS_FLAG         = 8'h0C;
   localparam logic [7:0] OFS_CTX          = 8'h10;
   localparam logic [7:0] OFS_CTX_EXT      = 8'h14;
   localparam logic [7:0] OFS_CHAN         = 8'h18;
   localparam logic [7:0] OFS_MCAST        = 8'h1C;
   localparam logic [7:0] OFS_MONITOR      = 8'h20;
   localparam logic [7:0] OFS_DUMP         = 8'h24;
   localparam logic [7:0] OFS_ING_LINK     = 8'h28;
   localparam logic [7:0] OFS_EGR_LINK     = 8'h2C;
   localparam logic [7:0] OFS_LINK_CFG     = 8'h30;
   localparam logic [7:0] OFS_GLOBAL_CFG   = 8'h34;
   localparam logic [7:0] OFS_MCAST_CFG    = 8'h38;
   localparam logic [7:0] OFS_LAST_ADDR    = 8'h3C;
   localparam logic [7:0] OFS_CELL_TIME    = 8'h40;
   localparam int         NUM_REGS         = 17;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int BASE_HI      = 23;
   localparam int BASE_LO      = 8;
   localparam int LCW_MASK_LO  = 24; // link_config_word: path_index_mask [35..24] -> stored 12 bits
   localparam int GCFG_NWORDS_LO = 0; // global_cfg: counter words-1 [1:0]
   localparam int GCFG_CTXW_LO = 4;  // context words-1 [6:4]
   localparam int GCFG_DUMP_LO = 8;  // dump_tbl_ctl [10:8]
   localparam int GCFG_MONALL  = 12; // monitor_all_conns
   localparam int GCFG_CHAN_EN = 13; // channel lookup enable
   localparam int COMMON_ING_MON_PTR_VALID  = 31;
   localparam int COMMON_EGR_MON_PTR_VALID  = 30;
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
   localparam logic [21:0] NO_BUCKET   = 22'h3F_FFFF;
   localparam logic [3:0]  ING_LINK_WORDS = 4'h5;
   localparam logic [3:0]  EGR_LINK_WORDS = 4'h4;
   // ---------------------------------------------------------------
   // table selection
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      TBL_ING_BILL, TBL_POLICE, TBL_EGR_BILL, TBL_FLAG, TBL_CTX, TBL_CTX_EXT,
      TBL_PATH, TBL_CHAN, TBL_MCAST, TBL_BUCKET, TBL_MONITOR, TBL_DUMP,
      TBL_ING_LINK, TBL_EGR_LINK
   } table_sel_t;
   typedef struct packed {
      table_sel_t  table_sel;
      logic        use_egress;
      logic [15:0] ing_conn_id;
      logic [15:0] egr_conn_id;
      logic [11:0] path_id;
      logic [15:0] chan_offset;
      logic [15:0] chan_id;
      logic [15:0] chan_index_mask;
      logic [3:0]  mcast_section;
      logic [15:0] mcast_ident;
      logic [31:0] common_word;
      logic [4:0]  link_num;
   } access_req_t;
   typedef struct packed {
      logic        valid;
      logic [23:0] addr;
      logic        word_wide;
      logic        no_bucket;
      logic [2:0]  bucket_num;
      logic        mon_valid;
   } access_rsp_t;
endpackage : rec_addr_pkg
`default_nettype wire

// ===== dv/rec_mem_model.sv
// external table memory model that watches the generated record addresses
`default_nettype none
module rec_mem_model (
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      arst_n,
   // generated access
   input  wire rec_addr_pkg::access_rsp_t rsp,
   // access statistics and read data
   output logic [15:0]                    n_access,
   output logic [15:0]                    n_misaligned,
   output logic [31:0]                    rd_data
);
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // one memory access per generated address
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         n_access     <= 16'h0000;
         n_misaligned <= 16'h0000;
         rd_data      <= 32'h5A5A_A5A5;
      end else if (rsp.valid) begin
         n_access <= n_access + 16'h0001;
         // long words sit on 4-byte, words on 2-byte boundaries
         if (rsp.addr[0] || (!rsp.word_wide && rsp.addr[1])) begin
            n_misaligned <= n_misaligned + 16'h0001;
         end
         // contents follow the address; idle cycles invert the held word, so it repeats every second idle cycle
         rd_data <= {8'hA5, ~rsp.addr};
      end else begin
         rd_data <= ~rd_data;
      end
   end
endmodule : rec_mem_model
`default_nettype wire

// ===== dv/tb_ext_mem_record_address_gen.sv
// self-checking bench for the record address generator
`default_nettype none
module tb_ext_mem_record_address_gen;
   timeunit 1ns;
   timeprecision 1ns;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   typedef struct {
      string       nm;
      logic [23:0] ea;
      logic        ww;
      logic        bk;
      logic        nb;
      logic [2:0]  bn;
      logic        mv;
   } exp_t;
   logic                      clk_sys;
   logic                      arst_n;
   logic                      psel, penable, pwrite;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata;
   logic                      pready, pslverr;
   logic                      req_valid, cell_tick;
   rec_addr_pkg::access_req_t req, rq;
   rec_addr_pkg::access_rsp_t rsp;
   logic [15:0]               n_access, n_misaligned;
   logic [31:0]               bv [12];
   logic [7:0]                ofs [12];
   logic [31:0]               rd;
   logic                      er;
   exp_t                      exp_q [$];
   exp_t                      e;
   int                        err_count, n_tests, n_sent, nc, nbits;
   ext_mem_record_address_gen u_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req(req), .cell_tick(cell_tick), .rsp(rsp)
   );
   rec_mem_model u_mem (
      .clk_sys(clk_sys), .arst_n(arst_n), .rsp(rsp), .n_access(n_access),
      .n_misaligned(n_misaligned), .rd_data()
   );
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk_word(input string nm, input logic [31:0] xp, input logic [31:0] got);
      n_tests++;
      if (got !== xp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, xp, got);
      end
   endtask : chk_word
   task automatic chk_addr(input string nm, input logic [23:0] xp, input logic [23:0] got);
      n_tests++;
      if (got !== xp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, xp, got);
      end
   endtask : chk_addr
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      req_valid <= 1'h0;
      psel      <= 1'h1;
      penable   <= 1'h0;
      pwrite    <= wr;
      paddr     <= a;
      pwdata    <= wd;
      @(posedge clk_sys);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) chk_word("pready", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
   endtask : apb
   task automatic cfg(input int nw, input int cw, input int d, input int mon, input int chan);
      apb(1'h1, rec_addr_pkg::OFS_GLOBAL_CFG,
          32'(nw - 1) | (32'(cw - 1) << 4) | (32'(d) << 8) | (32'(mon) << 12) | (32'(chan) << 13));
   endtask : cfg
   task automatic acc(input string nm, input rec_addr_pkg::table_sel_t t, input logic [31:0] ea,
                      input logic ww, input logic bk = 1'h0, input logic nb = 1'h0,
                      input logic [2:0] bn = 3'h0, input logic mv = 1'h0);
      exp_t x;
      rec_addr_pkg::access_req_t r;
      x = '{nm, ea[23:0], ww, bk, nb, bn, mv};
      r = rq;
      r.table_sel = t;
      exp_q.push_back(x);
      n_sent++;
      req       <= r;
      req_valid <= 1'h1;
      @(posedge clk_sys);
   endtask : acc
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // ---------------------------------------------------------------
   // response monitor, sampled mid-cycle
   // ---------------------------------------------------------------
   always @(negedge clk_sys) begin
      if (arst_n === 1'h1 && rsp.valid === 1'h1) begin
         if (exp_q.size() == 0) begin
            chk_word("spurious_valid", 32'h0, 32'h1);
         end else begin
            e = exp_q.pop_front();
            if (!(e.bk && e.nb)) chk_addr(e.nm, e.ea, rsp.addr);
            chk_word("word_wide", 32'(e.ww), 32'(rsp.word_wide));
            if (e.bk) begin
               chk_word("no_bucket", 32'(e.nb), 32'(rsp.no_bucket));
               chk_word("mon_valid", 32'(e.mv), 32'(rsp.mon_valid));
               if (!e.nb) chk_word("bucket_num", 32'(e.bn), 32'(rsp.bucket_num));
            end
         end
      end
   end
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      err_count++;
      end_of_test();
   end
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, req_valid, cell_tick, arst_n} = 6'h00;
      {paddr, pwdata, req, rq} = '0;
      {err_count, n_tests, n_sent} = 0;
      ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'h1;
      for (int i = 0; i < rec_addr_pkg::NUM_REGS; i++) begin
         apb(1'h0, 8'(4 * i), 32'h0);
         chk_word("reset_value", 32'h0, rd);
      end
      apb(1'h0, 8'h44, 32'h0);
      chk_word("unmapped_err", 32'h1, 32'(er));
      apb(1'h1, rec_addr_pkg::OFS_LAST_ADDR, 32'h0000_1234);
      chk_word("read_only_err", 32'h1, 32'(er));
      for (int i = 0; i < 12; i++) begin
         bv[i] = 32'h0010_0000 * (i + 1) + 32'h0000_0100 * i;
         apb(1'h1, ofs[i], bv[i]);
         apb(1'h0, ofs[i], 32'h0);
         chk_word("base_readback", bv[i], rd);
      end
      $display("test registers done");
      rq.ing_conn_id = 16'hFFFF;
      rq.egr_conn_id = 16'h8001;
      for (int n = 1; n <= 8; n++) begin
         nc = ((n - 1) % 4) + 1;
         cfg(nc, n, 0, 0, 1);
         acc("ing_bill", rec_addr_pkg::TBL_ING_BILL, bv[0] + 32'hFFFF * nc * 4, 1'h0);
         acc("police", rec_addr_pkg::TBL_POLICE, bv[1] + 32'hFFFF * nc * 4, 1'h0);
         acc("egr_bill", rec_addr_pkg::TBL_EGR_BILL, bv[2] + 32'h8001 * nc * 4, 1'h0);
         rq.use_egress = n[0];
         acc("ctx", rec_addr_pkg::TBL_CTX, bv[4] + (n[0] ? 32'h8001 : 32'hFFFF) * n * 4, 1'h0);
         acc("ctx_ext", rec_addr_pkg::TBL_CTX_EXT, bv[5] + (n[0] ? 32'h8001 : 32'hFFFF) * 4, 1'h0);
      end
      rq.use_egress = 1'h0;
      rq.ing_conn_id = 16'h0000;
      acc("ctx_ext_zero", rec_addr_pkg::TBL_CTX_EXT, bv[5], 1'h0);
      rq.ing_conn_id = 16'hFFFF;
      rq.link_num = 5'h1F;
      rq.path_id = 12'hABC;
      rq.chan_offset = 16'h1234;
      rq.chan_id = 16'hFFFF;
      rq.chan_index_mask = 16'h00FF;
      apb(1'h1, rec_addr_pkg::OFS_LINK_CFG, 32'hF045_67F0);
      acc("flag", rec_addr_pkg::TBL_FLAG, bv[3] + 32'hFFFF * 4, 1'h1);
      acc("ing_link", rec_addr_pkg::TBL_ING_LINK, bv[10] + 32'h1F * 20, 1'h0);
      acc("egr_link", rec_addr_pkg::TBL_EGR_LINK, bv[11] + 32'h1F * 16, 1'h0);
      rq.link_num = 5'h00;
      acc("link_zero", rec_addr_pkg::TBL_EGR_LINK, bv[11], 1'h0);
      acc("path_full", rec_addr_pkg::TBL_PATH, 32'h0045_6700 + 32'hA0C * 4, 1'h0);
      acc("chan", rec_addr_pkg::TBL_CHAN, bv[6] + 32'h1234 * 4 + 32'hFF * 2, 1'h1);
      cfg(1, 1, 0, 0, 0);
      acc("path_word", rec_addr_pkg::TBL_PATH, 32'h0067_F000 + 32'hA0C * 2, 1'h1);
      rq.mcast_section = 4'hA;
      rq.mcast_ident = 16'hFFFF;
      for (int i = 0; i < 8; i++) begin
         apb(1'h1, rec_addr_pkg::OFS_MCAST_CFG, 32'(i));
         acc("mcast", rec_addr_pkg::TBL_MCAST, bv[7] + ((32'hA << (i + 9)) | ((32'h1 << (i + 9)) - 1)) * 2, 1'h1);
      end
      $display("test table addresses done");
      rq.common_word = 32'hAAF0_1234;
      acc("monitor", rec_addr_pkg::TBL_MONITOR, bv[8] + 32'hABC * 32, 1'h0);
      acc("bucket", rec_addr_pkg::TBL_BUCKET, 32'h1234 * 4, 1'h0, 1'h1, 1'h0, 3'h4, 1'h1);
      rq.common_word = 32'h0000_FFFF;
      acc("bucket_none", rec_addr_pkg::TBL_BUCKET, 32'h0, 1'h0, 1'h1, 1'h1, 3'h0, 1'h0);
      cfg(1, 1, 0, 1, 1);
      for (int k = 0; k < 4; k++) begin
         rq.common_word = 32'h4000_0000 | (32'(k) << 28) | 32'h05A5_0123;
         acc("bucket_all", rec_addr_pkg::TBL_BUCKET, 32'h5A5 * 4, 1'h0, 1'h1, 1'h0,
             (k == 0) ? 3'h4 : 3'(k), 1'h1);
         acc("monitor_all", rec_addr_pkg::TBL_MONITOR, bv[8] + 32'h123 * 32, 1'h0);
      end
      rq.common_word = 32'h0FFF_0000;
      acc("bucket_none_all", rec_addr_pkg::TBL_BUCKET, 32'h0, 1'h0, 1'h1, 1'h1, 3'h0, 1'h0);
      $display("test common word done");
      req_valid <= 1'h0;
      repeat (300) begin
         cell_tick <= 1'h1;
         @(posedge clk_sys);
      end
      cell_tick <= 1'h0;
      apb(1'h0, rec_addr_pkg::OFS_CELL_TIME, 32'h0);
      chk_word("cell_time", 32'd300, rd);
      for (int d = 0; d < 8; d++) begin
         cfg(1, 1, d, 0, 1);
         nbits = (2 * (d + 2) + 1 > 16) ? 16 : 2 * (d + 2) + 1;
         acc("dump", rec_addr_pkg::TBL_DUMP, bv[9] + (32'd300 & ((32'h1 << nbits) - 1)) * 8, 1'h0);
      end
      apb(1'h0, rec_addr_pkg::OFS_LAST_ADDR, 32'h0);
      apb(1'h0, rec_addr_pkg::OFS_LAST_ADDR, 32'h0);
      chk_word("last_addr", (bv[9] + 32'd300 * 8) & 32'h00FF_FFFF, rd);
      chk_word("pending", 32'h0, 32'(exp_q.size()));
      chk_word("mem_accesses", 32'(n_sent), 32'(n_access));
      chk_word("mem_misaligned", 32'h0, 32'(n_misaligned));
      $display("test dump and summary done");
      end_of_test();
   end
endmodule : tb_ext_mem_record_address_gen
`default_nettype wire
